// *** verilog/ssc_top.sv ***
// Purpose: synchronous serial channel
// Assumes: inputs synchronous to clk_sys
// Notes:   internal transfer clock only
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ssc_defs.svh"

// Functional notes
// [RULE_01] Control 0 bits 1:0 pick the divider input, 01 meaning clk/8.
// [RULE_02] Control 0 bit 5 at 0 keeps the data output a driven push-pull.
// [RULE_03] Control 0 bit 6 at 0: data change on falling, sample on rising.
// [RULE_04] Control 1 bit 5 at 0: receive only happens while sending.
// [RULE_05] The rate register n divides the selected source by n+1.
// [RULE_06] The divider output is halved to make the transfer clock.
// [RULE_07] Transmission runs only while control 1 bit 0 is set.
// [RULE_08] Received bits are taken only while control 1 bit 2 is set.
// [RULE_09] The received byte reads in bits 7:0 of the receive register.
// [RULE_10] Receive flags: overrun b12, framing b13, parity b14, sum b15.
// [RULE_11] Software reads each byte and its flags before the next one.
// [RULE_12] Software writes each outgoing byte to the transmit register.
// [RULE_13] Mode field 001 with direction bit 0 runs the channel here.
// [RULE_14] Control 0 bit 7 at 0 shifts least significant bit first.
// [RULE_15] Eight bits move each way per transfer; clock idles between.
module ssc_top #(
    parameter int ADDR_W = 8,
    parameter int DEPTH  = 2
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output var  logic              s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output var  logic              s_axi_wready,
    // axi4-lite write response
    output var  logic [1:0]        s_axi_bresp,
    output var  logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output var  logic              s_axi_arready,
    // axi4-lite read data
    output var  logic [31:0]       s_axi_rdata,
    output var  logic [1:0]        s_axi_rresp,
    output var  logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // serial link
    input  wire logic              serial_in_pin,
    output var  logic              serial_out_pin,
    output var  logic              serial_out_oe_b,
    output var  logic              transfer_clk_out
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [7:0]          ctrl0_reg;
    logic [7:0]          ctrl1_reg;
    logic [7:0]          rate_reg;
    logic [3:0]          mode_reg;
    logic [7:0]          rx_data_reg;
    logic                rx_full_reg;
    logic                ovr_reg;
    logic                aw_hold_reg;
    logic [ADDR_W-1:0]   aw_addr_reg;
    logic                w_hold_reg;
    logic [31:0]         w_data_reg;
    logic [3:0]          w_strb_reg;
    logic [4:0]          pre_cnt_reg;
    logic [7:0]          brg_cnt_reg;
    ssc_pkg::ssc_state_e state_reg;
    logic [2:0]          bit_cnt_reg;
    logic                half_reg;
    logic [7:0]          tx_sh_reg;
    logic [7:0]          rx_sh_reg;
    logic                sdo_next;
    logic                oe_b_next;
    ssc_pkg::ssc_reg_e   wr_sel;
    ssc_pkg::ssc_reg_e   rd_sel;
    logic                wr_fire;
    logic                rd_fire;
    logic                rx_read;
    logic                chan_on;
    logic                src_tick;
    logic                brg_hit;
    logic                dummy_req;
    logic                start;
    logic                lsb_first;
    logic                idle_lvl;
    logic [31:0]         rd_word;

    ssc_stream_if #(.W(8)) wr_s ();
    ssc_stream_if #(.W(8)) rd_s ();

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    // shared address decode
    function automatic ssc_pkg::ssc_reg_e dec_f(
        input logic [ADDR_W-1:0] a);
        logic [7:0] o;
        o = 8'(a);
        if (a[ADDR_W-1:0] != ADDR_W'(o)) begin
            dec_f = ssc_pkg::SSC_R_NONE;
        end else begin
            case (o)
                `SSC_OFS_CTRL0:  dec_f = ssc_pkg::SSC_R_CTRL0;
                `SSC_OFS_CTRL1:  dec_f = ssc_pkg::SSC_R_CTRL1;
                `SSC_OFS_RATE:   dec_f = ssc_pkg::SSC_R_RATE;
                `SSC_OFS_RXHOLD: dec_f = ssc_pkg::SSC_R_RXHOLD;
                `SSC_OFS_TXHOLD: dec_f = ssc_pkg::SSC_R_TXHOLD;
                `SSC_OFS_MODE:   dec_f = ssc_pkg::SSC_R_MODE;
                `SSC_OFS_STATUS: dec_f = ssc_pkg::SSC_R_STATUS;
                default:         dec_f = ssc_pkg::SSC_R_NONE;
            endcase
        end
    endfunction

    // source tick select
    function automatic logic tick_f(input logic [1:0] sel,
                                    input logic [4:0] cnt);
        case (sel)
            `SSC_SRC_DIV1: tick_f = 1'b1;
            `SSC_SRC_DIV8: tick_f = (cnt[2:0] == `SSC_DIV8_LAST);
            default:       tick_f = (cnt == `SSC_DIV32_LAST);
        endcase
    endfunction

    // ----------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------
    assign wr_sel = dec_f(aw_addr_reg);
    assign rd_sel = dec_f(s_axi_araddr);
    // a transmit write waits while the buffer is full
    assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid &&
                     !(wr_sel == ssc_pkg::SSC_R_TXHOLD && !wr_s.ready);
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rx_read = rd_fire && (rd_sel == ssc_pkg::SSC_R_RXHOLD);
    assign wr_s.valid = wr_fire && w_strb_reg[0] &&
                        (wr_sel == ssc_pkg::SSC_R_TXHOLD); // [RULE_12]
    assign wr_s.data  = w_data_reg[7:0];

    // address and data caught in either order
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            aw_hold_reg   <= 1'b0;
            aw_addr_reg   <= '0;
            s_axi_awready <= 1'b1;
            w_hold_reg    <= 1'b0;
            w_data_reg    <= '0;
            w_strb_reg    <= '0;
            s_axi_wready  <= 1'b1;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg   <= 1'b1;
                aw_addr_reg   <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (wr_fire) begin
                aw_hold_reg   <= 1'b0;
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg   <= 1'b1;
                w_data_reg   <= s_axi_wdata;
                w_strb_reg   <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (wr_fire) begin
                w_hold_reg   <= 1'b0;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // write response
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SSC_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            if (wr_sel == ssc_pkg::SSC_R_NONE ||
                wr_sel == ssc_pkg::SSC_R_RXHOLD ||
                wr_sel == ssc_pkg::SSC_R_STATUS) begin
                s_axi_bresp <= `SSC_RESP_SLVERR;
            end else begin
                s_axi_bresp <= `SSC_RESP_OKAY;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // config registers, lane 0
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ctrl0_reg <= `SSC_CTRL0_RST;
            ctrl1_reg <= `SSC_CTRL1_RST;
            rate_reg  <= `SSC_RATE_RST;
            mode_reg  <= `SSC_MODE_RST;
        end else if (wr_fire && w_strb_reg[0]) begin
            case (wr_sel)
                ssc_pkg::SSC_R_CTRL0: ctrl0_reg <= w_data_reg[7:0];
                ssc_pkg::SSC_R_CTRL1: ctrl1_reg <= w_data_reg[7:0];
                ssc_pkg::SSC_R_RATE:  rate_reg  <= w_data_reg[7:0];
                ssc_pkg::SSC_R_MODE:  mode_reg  <= w_data_reg[3:0];
                default: ;
            endcase
        end
    end

    // read mux; write-only words read as zero
    always_comb begin
        rd_word = '0;
        case (rd_sel)
            ssc_pkg::SSC_R_CTRL0:  rd_word[7:0] = ctrl0_reg;
            ssc_pkg::SSC_R_CTRL1:  rd_word[7:0] = ctrl1_reg;
            ssc_pkg::SSC_R_MODE:   rd_word[3:0] = mode_reg;
            ssc_pkg::SSC_R_RXHOLD: begin
                rd_word[7:0] = rx_data_reg;           // [RULE_09]
                rd_word[`SSC_RX_OVR] = ovr_reg;        // [RULE_10]
                rd_word[`SSC_RX_FRM] = 1'b0;           // [RULE_10]
                rd_word[`SSC_RX_PAR] = 1'b0;           // [RULE_10]
                rd_word[`SSC_RX_SUM] = ovr_reg;        // [RULE_10]
            end
            ssc_pkg::SSC_R_STATUS: begin
                rd_word[0] = (state_reg != ssc_pkg::SSC_IDLE);
                rd_word[1] = wr_s.ready;
                rd_word[2] = rx_full_reg;
            end
            default: ;
        endcase
    end

    // read channel
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `SSC_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= (rd_sel == ssc_pkg::SSC_R_NONE) ?
                             `SSC_RESP_SLVERR : `SSC_RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // transmit buffer
    // ----------------------------------------------------------------
    ssc_fifo2 #(
        .W     (8),
        .DEPTH (DEPTH)
    ) u_txbuf (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .in_s    (wr_s),
        .out_s   (rd_s)
    );

    // ----------------------------------------------------------------
    // rate generation
    // ----------------------------------------------------------------
    assign chan_on = (mode_reg[2:0] == `SSC_MODE_SYNC) &&
                     !mode_reg[`SSC_MD_DIR];               // [RULE_13]
    assign src_tick = tick_f(ctrl0_reg[`SSC_C0_SRC_HI:`SSC_C0_SRC_LO],
                             pre_cnt_reg);
    // zero once per n+1 ticks
    assign brg_hit = (state_reg == ssc_pkg::SSC_SHIFT) && src_tick &&
                     (brg_cnt_reg == 8'h00);               // [RULE_05]

    // free-running prescaler
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pre_cnt_reg <= '0;
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 5'h01;            // [RULE_01]
        end
    end

    // divider reloads while idle so a new rate starts clean
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            brg_cnt_reg <= '0;
        end else if (state_reg != ssc_pkg::SSC_SHIFT) begin
            brg_cnt_reg <= rate_reg;
        end else if (src_tick) begin
            if (brg_cnt_reg == 8'h00) begin
                brg_cnt_reg <= rate_reg;                   // [RULE_05]
            end else begin
                brg_cnt_reg <= brg_cnt_reg - 8'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // shifter
    // ----------------------------------------------------------------
    assign lsb_first = !ctrl0_reg[`SSC_C0_ORDER];          // [RULE_14]
    assign idle_lvl  = !ctrl0_reg[`SSC_C0_POL];            // [RULE_03]
    // continuous rx sends dummy bytes
    assign dummy_req = ctrl1_reg[`SSC_C1_CONT] &&
                       ctrl1_reg[`SSC_C1_RXEN] && !rx_full_reg; // [RULE_04]
    assign rd_s.ready = (state_reg == ssc_pkg::SSC_IDLE) && chan_on &&
                        ctrl1_reg[`SSC_C1_TXEN];           // [RULE_07]
    assign start = rd_s.ready && (rd_s.valid || dummy_req);

    // shifter state
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_reg   <= ssc_pkg::SSC_IDLE;
            bit_cnt_reg <= '0;
            half_reg    <= 1'b0;
            tx_sh_reg   <= '0;
            rx_sh_reg   <= '0;
        end else begin
            case (state_reg)
                ssc_pkg::SSC_IDLE: begin
                    if (start) begin
                        tx_sh_reg   <= rd_s.valid ? rd_s.data
                                                  : `SSC_DUMMY_BYTE;
                        bit_cnt_reg <= '0;
                        half_reg    <= 1'b0;
                        state_reg   <= ssc_pkg::SSC_SHIFT;
                    end
                end
                ssc_pkg::SSC_SHIFT: begin
                    // dropping enable or mode abandons the byte
                    if (!ctrl1_reg[`SSC_C1_TXEN] || !chan_on) begin
                        state_reg <= ssc_pkg::SSC_IDLE;    // [RULE_07]
                    end else if (brg_hit && !half_reg) begin
                        half_reg  <= 1'b1;
                        tx_sh_reg <= lsb_first ?
                                     {1'b0, tx_sh_reg[7:1]} :
                                     {tx_sh_reg[6:0], 1'b0}; // [RULE_14]
                    end else if (brg_hit) begin
                        half_reg  <= 1'b0;
                        rx_sh_reg <= lsb_first ?
                                     {serial_in_pin, rx_sh_reg[7:1]} :
                                     {rx_sh_reg[6:0], serial_in_pin};
                        bit_cnt_reg <= bit_cnt_reg + 3'h1; // [RULE_15]
                        if (bit_cnt_reg == `SSC_LAST_BIT) begin
                            state_reg <= ssc_pkg::SSC_DONE;
                        end
                    end
                end
                ssc_pkg::SSC_DONE: state_reg <= ssc_pkg::SSC_IDLE;
                default:           state_reg <= ssc_pkg::SSC_IDLE;
            endcase
        end
    end

    // transfer clock toggles on each divider hit: period
    // 2*(n+1) ticks, idle level between bytes
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            transfer_clk_out <= 1'b1;
        end else if (state_reg != ssc_pkg::SSC_SHIFT) begin
            transfer_clk_out <= idle_lvl;                  // [RULE_15]
        end else if (brg_hit) begin
            transfer_clk_out <= !transfer_clk_out;         // [RULE_06]
        end
    end

    // leading edge puts out a bit
    always_comb begin
        sdo_next = serial_out_pin;
        if (state_reg == ssc_pkg::SSC_SHIFT && brg_hit && !half_reg) begin
            sdo_next = lsb_first ? tx_sh_reg[0] : tx_sh_reg[7];
        end else if (state_reg == ssc_pkg::SSC_IDLE) begin
            sdo_next = 1'b1;
        end
        // open-drain only pulls low; push-pull drives whenever the channel is on
        if (!chan_on) begin
            oe_b_next = 1'b1;
        end else if (!ctrl0_reg[`SSC_C0_DRIVE]) begin
            oe_b_next = 1'b0;                              // [RULE_02]
        end else begin
            oe_b_next = sdo_next;
        end
    end

    // pin and enable registered together
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            serial_out_pin  <= 1'b1;
            serial_out_oe_b <= 1'b1;
        end else begin
            serial_out_pin  <= sdo_next;
            serial_out_oe_b <= oe_b_next;
        end
    end

    // ----------------------------------------------------------------
    // receive holding
    // ----------------------------------------------------------------
    // a byte finishing in the same cycle as a read keeps its flags set
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rx_data_reg <= '0;
            rx_full_reg <= 1'b0;
            ovr_reg     <= 1'b0;
        end else if (state_reg == ssc_pkg::SSC_DONE &&
                     ctrl1_reg[`SSC_C1_RXEN]) begin        // [RULE_08]
            rx_data_reg <= rx_sh_reg;                      // [RULE_09]
            rx_full_reg <= 1'b1;
            if (rx_full_reg && !rx_read) begin
                ovr_reg <= 1'b1;                           // [RULE_10]
            end
        end else if (rx_read) begin
            rx_full_reg <= 1'b0;
            ovr_reg     <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// *** inc/ssc_defs.svh ***
// Purpose: serial channel constants
// Assumes: one 32-bit word per register
// Notes:   definitions only
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SSC_OFS_CTRL0    8'h00
`define SSC_OFS_CTRL1    8'h04
`define SSC_OFS_RATE     8'h08
`define SSC_OFS_RXHOLD   8'h0c
`define SSC_OFS_TXHOLD   8'h10
`define SSC_OFS_MODE     8'h14
`define SSC_OFS_STATUS   8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SSC_C0_SRC_LO    0
`define SSC_C0_SRC_HI    1
`define SSC_C0_DRIVE     5
`define SSC_C0_POL       6
`define SSC_C0_ORDER     7
`define SSC_C1_TXEN      0
`define SSC_C1_RXEN      2
`define SSC_C1_CONT      5
`define SSC_MD_DIR       3
`define SSC_RX_OVR       12
`define SSC_RX_FRM       13
`define SSC_RX_PAR       14
`define SSC_RX_SUM       15

// ----------------------------------------------------------------
// encodings, reset values, counts
// ----------------------------------------------------------------
`define SSC_SRC_DIV1     2'h0
`define SSC_SRC_DIV8     2'h1
`define SSC_MODE_SYNC    3'h1
`define SSC_CTRL0_RST    8'h00
`define SSC_CTRL1_RST    8'h00
`define SSC_RATE_RST     8'h00
`define SSC_MODE_RST     4'h0
`define SSC_DIV8_LAST    5'h07
`define SSC_DIV32_LAST   5'h1f
`define SSC_LAST_BIT     3'h7
`define SSC_DUMMY_BYTE   8'hff
`define SSC_RESP_OKAY    2'h0
`define SSC_RESP_SLVERR  2'h2

`endif

// *** inc/ssc_pkg.sv ***
// Purpose: types shared by the synchronous serial channel files
// Assumes: nothing
// Notes:   constants live in ssc_defs.svh
package ssc_pkg;

    // shifter states, gray along idle -> shift -> done
    typedef enum logic [1:0] {
        SSC_IDLE  = 2'b00,
        SSC_SHIFT = 2'b01,
        SSC_DONE  = 2'b11
    } ssc_state_e;

    // decoded register
    typedef enum logic [2:0] {
        SSC_R_CTRL0, SSC_R_CTRL1, SSC_R_RATE, SSC_R_RXHOLD,
        SSC_R_TXHOLD, SSC_R_MODE, SSC_R_STATUS, SSC_R_NONE
    } ssc_reg_e;

endpackage

// *** inc/ssc_stream_if.sv ***
// Purpose: valid/ready byte stream between channel modules
// Assumes: single clock
// Notes:   src drives valid and data, snk drives ready
`timescale 1ns/1ns
`default_nettype none
interface ssc_stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** verilog/ssc_fifo2.sv ***
// Purpose: two-entry byte buffer
// Assumes: synchronous active-low reset
// Notes:   depth is a power of two; default two entries
`timescale 1ns/1ns
`default_nettype none
module ssc_fifo2 #(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic   clk_sys,
    input  wire logic   rst_b,
    // fill and drain sides
    ssc_stream_if.snk   in_s,
    ssc_stream_if.src   out_s
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] rp_reg;
    logic [AW:0]   cnt_reg;
    logic          push;
    logic          pop;

    // full and empty come from the count, so both are exact
    assign in_s.ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_s.valid = (cnt_reg != '0);
    assign out_s.data  = mem_reg[rp_reg];
    assign push = in_s.valid && in_s.ready;
    assign pop  = out_s.valid && out_s.ready;

    // storage
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_reg[wp_reg] <= in_s.data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wp_reg <= wp_reg + AW'(1);
            end
            if (pop) begin
                rp_reg <= rp_reg + AW'(1);
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + (AW+1)'(1);
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - (AW+1)'(1);
            end
        end
    end
endmodule
`default_nettype wire

// *** verilog/ssc_top_unused_guard.sv ***
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// *** testbench/ssc_top_properties.sv ***
// Purpose: port checker for the serial channel
// Assumes: top-level ports only
// Notes: bound after the module
`timescale 1ns/1ns
`default_nettype none
module ssc_props #(parameter int ADDR_W = 8, parameter int DEPTH = 2) (
    // clock, reset
    input wire logic              clk_sys,
    input wire logic              rst_b,
    // register bus
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    // link
    input wire logic              serial_out_pin,
    input wire logic              serial_out_oe_b
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // both halves of a write taken at one edge
    sequence aw_w;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    rst_idle_a: assert property ($rose(rst_b) |-> s_axi_awready
        && !s_axi_bvalid && !s_axi_rvalid && serial_out_oe_b) else $error("reset");
    wr_resp_a: assert property (aw_w and s_axi_awaddr != 8'h10
        |-> ##[1:2] s_axi_bvalid) else $error("no bvalid");
    aw_block_a: assert property (aw_w |=> !s_axi_awready && !s_axi_wready)
        else $error("write taken twice");
    b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid stuck");
    rd_resp_a: assert property (rd_take |=> s_axi_rvalid) else $error("no read");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken twice");
    r_done_a: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid && s_axi_arready) else $error("rvalid stuck");
    idle_out_a: assert property (serial_out_oe_b |-> serial_out_pin)
        else $error("released output not high");
endmodule
bind ssc_top ssc_props #(.ADDR_W(ADDR_W), .DEPTH(DEPTH)) u_props (.*);
`default_nettype wire

// *** testbench/ssc_peer.sv ***
// Purpose: clocked serial peer on the link
// Assumes: polarity 0, lsb first
// Notes: line toggles between frames, it has no pull
`timescale 1ns/1ns
`default_nettype none
module ssc_peer (
    input wire logic       rst_b,
    input wire logic       transfer_clk_out,
    input wire logic       serial_out_pin,
    input wire logic [7:0] peer_byte,
    output var logic       serial_in_pin,
    output var logic [7:0] peer_rx
);
    logic [2:0] idx = 3'h0;
    initial serial_in_pin = 1'b0;
    // drive on falling edge
    always @(negedge transfer_clk_out) serial_in_pin <= peer_byte[idx];
    // capture on rising edge
    always @(posedge transfer_clk_out) begin
        peer_rx <= {serial_out_pin, peer_rx[7:1]};
        idx <= rst_b ? idx + 3'h1 : 3'h0;
        if (idx == 3'h7) serial_in_pin <= ~serial_in_pin;
    end
endmodule
`default_nettype wire

// *** testbench/test_sync_serial_channel_setup.sv ***
// Purpose: serial channel bench
// Assumes: internal clock, clk/8 source
// Notes: waits are bounded
`timescale 1ns/1ns
`default_nettype none
module test_sync_serial_channel_setup;
    logic clk_sys = 0, rst_b = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, peer_byte = 0, peer_rx;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, serial_in_pin, serial_out_pin, serial_out_oe_b;
    logic transfer_clk_out;
    int err_count = 0, check_count = 0, i, n;
    ssc_top DUT (.*);
    ssc_peer u_peer (.*);
    always #20 clk_sys = ~clk_sys;
    task print_verdict;
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task lim(input int k);
        if (k >= 2000) begin
            chk(k, 0);
            print_verdict();
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        i = 0;
        do begin
            @(posedge clk_sys);
            i++;
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) s_axi_bready <= 0;
        end while (s_axi_bready && i < 2000);
        lim(i);
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        i = 0;
        do begin
            @(posedge clk_sys);
            i++;
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) {s_axi_rready, d, r} <= {1'b0, s_axi_rdata, s_axi_rresp};
        end while (s_axi_rready && i < 2000);
        lim(i);
    endtask
    // poll status bit
    task wt(input int b, input logic v);
        n = 0;
        do begin
            rd(8'h18);
            n++;
        end while (d[b] !== v && n < 2000);
        lim(n);
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_b <= 1;
        rd(8'h00);
        chk(d, 0);
        rd(8'h40);
        chk(r, 2);
        wr(8'h14, 1);
        wr(8'h00, 1);
        wr(8'h08, 9);
        wr(8'h04, 5);
        peer_byte <= 8'h3c;
        wr(8'h10, 8'ha5);
        // half period: 8 * (9 + 1) clocks
        for (i = 0; transfer_clk_out !== 0 && i < 2000; i++)
            @(posedge clk_sys);
        lim(i);
        for (n = 0; transfer_clk_out === 0 && n < 2000; n++)
            @(posedge clk_sys);
        chk(n, 80);
        wt(2, 1);
        rd(8'h0c);
        chk(d, 32'h3c);
        chk(peer_rx, 8'ha5);
        // two unread bytes: overrun
        peer_byte <= 8'h81;
        wr(8'h10, 8'h11);
        wr(8'h10, 8'h22);
        wt(2, 1);
        wt(0, 0);
        rd(8'h0c);
        chk(d, 32'h9081);
        rd(8'h0c);
        chk(d & 32'hf000, 0);
        chk(peer_rx, 8'h22);
        wr(8'h04, 1);
        wr(8'h10, 8'h5a);
        wt(0, 1);
        wt(0, 0);
        chk(d[2], 0);
        wr(8'h04, 0);
        wr(8'h10, 8'h66);
        n = 0;
        repeat (200) @(posedge clk_sys) n += (transfer_clk_out !== 1);
        chk(n, 0);
        print_verdict();
    end
endmodule
`default_nettype wire
